// [common/kse_pkg.sv]
// Package of constants and types for the keyboard serial encoder
package kse_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned BIT_RATE_HZ = 110;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned DEBOUNCE_MS = 10;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;

  // ------------------------------------------------------------
  // Widths and layout
  // ------------------------------------------------------------
  localparam int unsigned NUM_KEYS = 60;
  localparam int unsigned CODE_W = 15;
  localparam int unsigned CHAR_W = 7;
  localparam int unsigned SHIFT_W = 20;
  localparam int unsigned BS_W = 7;
  localparam int unsigned KEY_IDX_W = 6;
  localparam int unsigned REG_ADDR_W = 4;
  localparam int unsigned BIT_CNT_W = 5;

  // Register byte offsets
  localparam logic [REG_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [REG_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [REG_ADDR_W-1:0] LAMP_OFFSET = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_ANALYZER_BIT = 0;
  localparam int unsigned CTRL_EXTCLK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic ready_lamp;
    logic busy_lamp;
    logic query_lamp;
    logic [BS_W-1:0] bs_lamps;
  } kse_lamps_t;

  typedef struct packed {
    logic step_n;
    logic repeat_n;
  } kse_levers_t;

endpackage

// [tb/kse_proc_rx.sv]
// Model of the processor serial receiver taking encoded key frames
`timescale 1ns/100ps
module kse_proc_rx #(
  parameter int unsigned DIV = 8
) (
  input wire logic clk, // Reference clock
  input wire logic rxd, // Serial line from encoder
  output logic [6:0] char0, // First character
  output logic [6:0] char1, // Second character
  output int frames, // Frames taken
  output logic frame_err // Framing level wrong
);
  logic [19:0] bits;
  initial begin
    frames = 0;
    frame_err = 1'b0;
  end
  // Hunt start edge, sample mid-bit, first bit first
  always begin
    @(negedge rxd);
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      bits[i] = rxd;
      if (i < 19) repeat (DIV) @(posedge clk);
    end
    if (bits[0] || bits[10] || !(&{bits[9:8], bits[19:18]})) frame_err = 1'b1;
    char0 = bits[7:1];
    char1 = bits[17:11];
    frames++;
  end
endmodule

// [tb/kse_top_assertions.sv]
// Port relation checker for the keyboard serial encoder
`timescale 1ns/100ps
module kse_top_assertions #(
  parameter int unsigned NKEYS = 60
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Slave response
  input wire logic [NKEYS-1:0] key_n, // Key lines
  input wire logic serial_char_in, // Terminal input
  input wire logic term_sense_open, // Terminal absent
  input wire logic serial_char_out, // Serial output
  input wire logic matrix_energize, // Matrix energize
  input wire logic stop_out, // Stop flop
  input wire logic ready_in_n, // Ready input
  input wire logic query_level_in, // Query input
  input wire logic [6:0] block_size_selects, // Block size in
  input wire logic [6:0] block_size_to_adc, // Block size out
  input wire kse_pkg::kse_lamps_t lamps, // Lamp drives
  input wire logic step_lever, // Step lever
  input wire kse_pkg::kse_levers_t levers, // Lever outputs
  input wire logic [15:0] switch_in, // Switches in
  input wire logic [15:0] switch_out // Switches out
);
  // Armed one edge after release, so no attempt sees reset values
  logic live_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!live_q);

  // Stop held long enough for any lamp latency
  sequence stop_held;
    stop_out [*3];
  endsequence

  // Port relations
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  energize_key_a: assert property (
    $onehot(~key_n) |-> matrix_energize)
    else $error("matrix not energized");
  energize_idle_a: assert property (&key_n |-> !matrix_energize)
    else $error("matrix energized with no key");
  ready_lamp_a: assert property (!ready_in_n |=> lamps.ready_lamp)
    else $error("ready lamp dark");
  busy_lamp_a: assert property (ready_in_n |=> lamps.busy_lamp)
    else $error("busy lamp dark");
  stop_ready_a: assert property (stop_held |-> lamps.ready_lamp)
    else $error("stop did not light ready");
  query_lamp_a: assert property (
    ##1 lamps.query_lamp != $past(query_level_in))
    else $error("query lamp wrong");
  bs_forward_a: assert property (
    ##1 block_size_to_adc == $past(block_size_selects)
    && lamps.bs_lamps == ~$past(block_size_selects))
    else $error("block size not forwarded");
  switch_pass_a: assert property (
    ##1 switch_out == $past(switch_in))
    else $error("switch path altered");
  step_lever_a: assert property (step_lever |=> !levers.step_n)
    else $error("step not asserted");
  serial_pass_a: assert property (
    !serial_char_in && !term_sense_open |-> ##[1:3] !serial_char_out)
    else $error("terminal input not forwarded");
endmodule

bind kse_top kse_top_assertions #(.NKEYS(NKEYS)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .key_n(key_n), .serial_char_in(serial_char_in),
  .term_sense_open(term_sense_open), .serial_char_out(serial_char_out),
  .matrix_energize(matrix_energize), .stop_out(stop_out),
  .ready_in_n(ready_in_n), .query_level_in(query_level_in),
  .block_size_selects(block_size_selects),
  .block_size_to_adc(block_size_to_adc), .lamps(lamps),
  .step_lever(step_lever), .levers(levers), .switch_in(switch_in),
  .switch_out(switch_out));

// [tb/kse_top_tb.sv]
// Self-checking bench for the keyboard serial encoder
`timescale 1ns/100ps
module kse_top_tb;
  localparam int unsigned DIV = 8;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, serial_char_out, matrix_energize, stop_out, cont_out;
  logic [59:0] key_n = '1;
  logic analyzer_mode = 1, serial_char_in = 1, term_sense_open = 0;
  logic stop_key_n = 1, cont_key_n = 1, ready_in_n = 0, query_level_in = 1;
  logic step_lever = 0, repeat_lever = 0;
  logic [6:0] bss = 7'h7F, bs_adc, c0, c1;
  logic [15:0] sw_in = '0, sw_out;
  logic ferr;
  logic pup = 0, ebc = 0, ext_present = 0, ext_run = 0, rst_in = 0;
  logic [2:0] ext_cnt = '0;
  kse_pkg::kse_lamps_t lamps;
  kse_pkg::kse_levers_t levers;
  int failures = 0, total_checks = 0, cyc = 0, frames;

  kse_top #(.NKEYS(60), .BIT_DIV(DIV), .DEB_CYC(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .power_up_pulse(pup), .key_n(key_n),
    .analyzer_mode(analyzer_mode), .ext_bit_clk(ebc),
    .ext_clk_present(ext_present), .serial_char_in(serial_char_in),
    .term_sense_open(term_sense_open), .serial_char_out(serial_char_out),
    .matrix_energize(matrix_energize), .stop_key_n(stop_key_n),
    .cont_key_n(cont_key_n), .stop_out(stop_out), .cont_out(cont_out),
    .ready_in_n(ready_in_n), .query_level_in(query_level_in),
    .block_size_selects(bss), .block_size_to_adc(bs_adc), .lamps(lamps),
    .step_lever(step_lever), .repeat_lever(repeat_lever), .levers(levers),
    .switch_in(sw_in), .restart_in(rst_in), .switch_out(sw_out));

  kse_proc_rx #(.DIV(DIV)) rx_u (.clk(hclk), .rxd(serial_char_out),
    .char0(c0), .char1(c1), .frames(frames), .frame_err(ferr));

  // Clock and hang guard
  always #50 hclk = ~hclk;

  // External terminal bit clock, eight cycles a bit while enabled
  always @(posedge hclk) begin
    ext_cnt <= ext_run ? ext_cnt + 3'h1 : 3'h0;
    ebc <= ext_run & ext_cnt[2];
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      final_report;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One single-word bus transfer, waiting on ready
  task ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask

  task wait_frame(input int n);
    int t;
    t = 0;
    while (frames == n && t < 400) begin
      @(posedge hclk);
      t++;
    end
    chk("frame count", 32'(n + 1), 32'(frames));
  endtask

  task set_key(input int k, input logic v, input int hold);
    @(posedge hclk);
    key_n[k] <= v;
    repeat (hold) @(posedge hclk);
  endtask

  task t_panel;
    @(posedge hclk);
    {ready_in_n, query_level_in, bss} <= {2'b10, 7'h3F};
    {step_lever, sw_in, stop_key_n} <= {1'b1, 16'hA5C3, 1'b0};
    repeat (4) @(posedge hclk);
    chk("lamps", 32'h3C0, 32'(lamps));
    chk("bs out", 32'h3F, 32'(bs_adc));
    chk("levers", 32'h1, 32'(levers));
    chk("switches", 32'hA5C3, 32'(sw_out));
    chk("stop", 32'h1, 32'(stop_out));
    {analyzer_mode, stop_key_n, cont_key_n} <= 3'b010;
    {step_lever, repeat_lever} <= 2'b01;
    repeat (4) @(posedge hclk);
    chk("cont off", 32'h0, 32'(cont_out));
    chk("repeat lever", 32'h2, 32'(levers));
    analyzer_mode <= 1;
    repeat (4) @(posedge hclk);
    chk("cont on", 32'h1, 32'(cont_out));
    {cont_key_n, ready_in_n, query_level_in, bss} <= {3'b100, 7'h7E};
    $display("test panel done");
  endtask

  task t_bus;
    ahb(0, 32'h8, 0, rd);
    chk("lamp reg", 32'h281, rd);
    ahb(0, 32'h0, 0, rd);
    chk("ctrl reset", 32'h0, rd);
    ahb(0, 32'h20, 0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test bus done");
  endtask

  task t_keys;
    for (int k = 0; k < 60; k++) begin
      set_key(k, 0, 0);
      wait_frame(frames);
      chk("char0", 32'(8'h30 + k % 40), 32'(c0));
      chk("char1", 32'(8'h41 + k / 40), 32'(c1));
      set_key(k, 1, 20);
    end
    chk("framing", 32'h0, 32'(ferr));
    $display("test keys done");
  endtask

  task t_reject;
    int n;
    n = frames;
    set_key(7, 0, 0);
    wait_frame(n);
    set_key(3, 0, 300);
    chk("held key once", 32'(n + 1), 32'(frames));
    set_key(7, 1, 0);
    set_key(3, 1, 300);
    chk("two keys", 32'(n + 1), 32'(frames));
    @(posedge hclk);
    key_n <= ~60'h88;
    repeat (300) @(posedge hclk);
    chk("simultaneous", 32'(n + 1), 32'(frames));
    key_n <= '1;
    set_key(5, 0, 2);
    set_key(5, 1, 300);
    chk("bounce", 32'(n + 1), 32'(frames));
    $display("test reject done");
  endtask

  task t_mode;
    int n;
    @(posedge hclk);
    analyzer_mode <= 0;
    n = frames;
    set_key(9, 0, 300);
    chk("mode off", 32'(n), 32'(frames));
    set_key(9, 1, 20);
    ahb(1, 32'h0, 32'h1, rd);
    ahb(0, 32'h0, 0, rd);
    chk("ctrl", 32'h1, rd);
    set_key(9, 0, 0);
    wait_frame(n);
    chk("reg mode char", 32'h39, 32'(c0));
    set_key(9, 1, 20);
    ahb(1, 32'h0, 32'h0, rd);
    analyzer_mode <= 1;
    $display("test mode done");
  endtask

  // Restart status, external bit clock and power-up pulse
  task t_ext;
    int n;
    @(posedge hclk);
    {ext_present, rst_in} <= 2'b11;
    ahb(0, 32'h4, 0, rd);
    chk("restart status", 32'h1, 32'(rd[0]));
    set_key(11, 0, 40);
    chk("ext clock still", 32'h0, 32'(serial_char_out));
    pup <= 1;
    set_key(11, 1, 2);
    chk("power-up idle", 32'h1, 32'(serial_char_out));
    pup <= 0;
    repeat (200) @(posedge hclk);
    n = frames;
    ext_run <= 1;
    set_key(11, 0, 0);
    wait_frame(n);
    chk("ext char", 32'h3B, 32'(c0));
    set_key(11, 1, 20);
    {ext_present, ext_run, rst_in} <= 3'b000;
    $display("test ext done");
  endtask

  task t_pass;
    @(posedge hclk);
    serial_char_in <= 0;
    repeat (4) @(posedge hclk);
    chk("pass low", 32'h0, 32'(serial_char_out));
    term_sense_open <= 1;
    repeat (4) @(posedge hclk);
    chk("sense open", 32'h1, 32'(serial_char_out));
    $display("test pass done");
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1;
    t_panel;
    t_bus;
    t_keys;
    t_reject;
    t_mode;
    t_ext;
    t_pass;
    final_report;
  end
endmodule

// [verilog/kse_matrix.sv]
// Key matrix: one pressed key line to its 15-line code
`timescale 1ns/100ps
module kse_matrix #(
  parameter int unsigned NKEYS = 60
) (
  input wire logic [NKEYS-1:0] key_n, // Active-low key lines
  output logic [14:0] matrix_code_lines_n, // Active-low code lines
  output logic any_key, // Exactly one key down
  output logic multi_key // More than one key down
);

  // Start bit low, then two 7-bit characters, key index based
  function automatic logic [14:0] key_code(input int unsigned k);
    logic [6:0] c0;
    logic [6:0] c1;
    c0 = 7'(8'h30 + 8'(k % 40));
    c1 = 7'(8'h41 + 8'(k / 40));
    return {c1, c0, 1'b0};
  endfunction

  // Wired-AND diode matrix, codes are distinct per key
  always_comb begin
    logic [14:0] acc;
    int unsigned cnt;
    acc = 15'h7FFF;
    cnt = 0;
    for (int unsigned k = 0; k < NKEYS; k++) begin
      if (!key_n[k]) begin
        acc = acc & ~key_code(k);
        cnt = cnt + 1;
      end
    end
    matrix_code_lines_n = acc;
    any_key = (cnt == 1);
    multi_key = (cnt > 1);
  end

endmodule

// [verilog/kse_top.sv]
// Keyboard serial encoder: matrix, serializer, function and lamp logic
`timescale 1ns/100ps
// Summary of operation
// - Key pressed drives active-low 15-line code
// - Each of 60 keys has distinct code
// - Code loads 20-bit register, shifts serially
// - Shift only while analyzer mode enabled
// - 110 Hz bit clock unless external supplied
// - Bit clock runs only while register busy
// - Terminal serial input forwarded to output
// - Debounce; reject repeats and simultaneous keys
// - Energize matrix while a key is pressed
// - Power-up pulse forces defined control state
// - Stop/continue flops set only in analyzer mode
// - Ready lamp on low, busy on high
// - Stop output also lights ready lamp
// - Low query input lights query lamp
// - Block-size selects lit and forwarded
// - Levers assert active-low step and repeat
// - Switches pass through except restart
// - Missing terminal forces input line idle
module kse_top #(
  parameter int unsigned NKEYS = kse_pkg::NUM_KEYS,
  parameter int unsigned BIT_DIV = kse_pkg::BIT_CYCLES,
  parameter int unsigned DEB_CYC = kse_pkg::DEBOUNCE_CYCLES
) (
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  input wire logic power_up_pulse, // Power-on pulse, active high
  input wire logic [NKEYS-1:0] key_n, // Character keys, active low
  input wire logic analyzer_mode, // Analyzer-mode enable
  input wire logic ext_bit_clk, // External terminal bit clock
  input wire logic ext_clk_present, // External clock supplied
  input wire logic serial_char_in, // Terminal serial input
  input wire logic term_sense_open, // Terminal not connected
  output logic serial_char_out, // Serial data to processor
  output logic matrix_energize, // Matrix energize enable
  input wire logic stop_key_n, // Stop button, active low
  input wire logic cont_key_n, // Continue button, active low
  output logic stop_out, // Stop flop output
  output logic cont_out, // Continue flop output
  input wire logic ready_in_n, // Ready input, low is ready
  input wire logic query_level_in, // Query input, low lights
  input wire logic [6:0] block_size_selects, // Block size, active low
  output logic [6:0] block_size_to_adc, // Forwarded block size
  output kse_pkg::kse_lamps_t lamps, // Lamp drives
  input wire logic step_lever, // Lever in step position
  input wire logic repeat_lever, // Lever in repeat position
  output kse_pkg::kse_levers_t levers, // Step and repeat, low
  input wire logic [15:0] switch_in, // ADC and panel switches
  input wire logic restart_in, // Restart input
  output logic [15:0] switch_out // Switches to processor
);

  // ------------------------------------------------------------
  // Key matrix
  // ------------------------------------------------------------
  logic [14:0] code_n;
  logic one_key;
  logic many_keys;

  kse_matrix #(.NKEYS(NKEYS)) u_matrix (
    .key_n(key_n),
    .matrix_code_lines_n(code_n),
    .any_key(one_key),
    .multi_key(many_keys)
  );

  // ------------------------------------------------------------
  // Registers: control and status over AHB-Lite
  // ------------------------------------------------------------
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic ph_valid_q;
  logic ph_write_q;
  logic [kse_pkg::REG_ADDR_W-1:0] ph_addr_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic sw_analyzer;
  logic sw_extclk;
  logic run_enable;
  logic addr_ok;
  logic take;

  // Address phase capture
  assign take = hsel & htrans[1] & hready;
  assign addr_ok = (haddr[31:kse_pkg::REG_ADDR_W] == '0);
  assign sw_analyzer = ctrl_q[kse_pkg::CTRL_ANALYZER_BIT];
  assign sw_extclk = ctrl_q[kse_pkg::CTRL_EXTCLK_BIT];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= '0;
    end else begin
      ph_valid_q <= take & addr_ok;
      ph_write_q <= hwrite;
      ph_addr_q <= haddr[kse_pkg::REG_ADDR_W-1:0];
    end
  end

  // Control write in data phase
  assign ctrl_d = (ph_valid_q && ph_write_q &&
                   ph_addr_q == kse_pkg::CTRL_OFFSET) ?
                  hwdata[1:0] : ctrl_q;

  // ------------------------------------------------------------
  // Serializer state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_DEBOUNCE, ST_SEND, ST_RELEASE}
    kse_state_t;
  kse_state_t state_q;
  kse_state_t state_d;
  logic [kse_pkg::SHIFT_W-1:0] sh_q;
  logic [kse_pkg::SHIFT_W-1:0] sh_d;
  logic [kse_pkg::BIT_CNT_W-1:0] bits_q;
  logic [kse_pkg::BIT_CNT_W-1:0] bits_d;
  logic [31:0] div_q;
  logic [31:0] div_d;
  logic [31:0] deb_q;
  logic [31:0] deb_d;
  logic [14:0] code_q;
  logic ext_q;
  logic bit_tick;
  logic ext_rise;
  logic int_tick;
  logic term_line;
  logic busy;
  logic [kse_pkg::SHIFT_W-1:0] frame;

  // Run only in analyzer mode, from pin or register
  assign run_enable = analyzer_mode | sw_analyzer;
  // Missing terminal holds input at mark
  assign term_line = term_sense_open ? 1'b1 : serial_char_in;
  assign busy = (state_q == ST_SEND);
  // Internal clock runs only while busy
  assign int_tick = busy && (div_q == BIT_DIV - 1);
  assign ext_rise = ext_bit_clk & ~ext_q;
  // External clock replaces internal when supplied
  assign bit_tick = (ext_clk_present | sw_extclk) ?
                    (busy & ext_rise) : int_tick;
  // Two frames: start, 7 data, 2 stop each; LSB first
  // First start bit comes straight from the matrix start line (space)
  assign frame = {2'b11, code_q[14:8], 1'b0,
                  2'b11, code_q[7:1], code_q[0]};

  always_comb begin
    state_d = state_q;
    sh_d = sh_q;
    bits_d = bits_q;
    deb_d = '0;
    div_d = busy ? ((div_q == BIT_DIV - 1) ? '0 : div_q + 1) : '0;
    unique case (state_q)
      ST_IDLE: begin
        // Single key only, simultaneous presses rejected
        if (one_key && !many_keys && run_enable) begin
          state_d = ST_DEBOUNCE;
        end
      end
      ST_DEBOUNCE: begin
        // Key must hold steady for the debounce time
        if (!one_key || many_keys) begin
          state_d = ST_IDLE;
        end else if (deb_q == DEB_CYC - 1) begin
          sh_d = frame;
          bits_d = '0;
          state_d = ST_SEND;
        end else begin
          deb_d = deb_q + 1;
        end
      end
      ST_SEND: begin
        if (bit_tick && run_enable) begin
          sh_d = {1'b1, sh_q[kse_pkg::SHIFT_W-1:1]};
          bits_d = bits_q + 1'b1;
          if (bits_q == 5'(kse_pkg::SHIFT_W - 1)) begin
            state_d = ST_RELEASE;
          end
        end
      end
      ST_RELEASE: begin
        // Wait for all keys up so one press sends once
        if (!one_key && !many_keys) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // Latch code from matrix while debouncing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_q <= 15'h7FFF;
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_bit_clk;
      if (state_q == ST_DEBOUNCE) begin
        code_q <= ~code_n;
      end
    end
  end

  // Serializer and control flops, power-up pulse as reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      sh_q <= '1;
      bits_q <= '0;
      div_q <= '0;
      deb_q <= '0;
      ctrl_q <= kse_pkg::CTRL_RESET;
    end else if (power_up_pulse) begin
      state_q <= ST_IDLE;
      sh_q <= '1;
      bits_q <= '0;
      div_q <= '0;
      deb_q <= '0;
      ctrl_q <= kse_pkg::CTRL_RESET;
    end else begin
      state_q <= state_d;
      sh_q <= sh_d;
      bits_q <= bits_d;
      div_q <= div_d;
      deb_q <= deb_d;
      ctrl_q <= ctrl_d;
    end
  end

  // Output line: keyboard data ANDed with terminal data
  logic out_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_q <= 1'b1;
    end else begin
      out_q <= (busy ? sh_q[0] : 1'b1) & term_line;
    end
  end
  assign serial_char_out = out_q;

  // Energize matrix whenever any key is down
  // Held keys stay energized; the release state only blocks a resend
  assign matrix_energize = one_key | many_keys;

  // ------------------------------------------------------------
  // Function logic: stop and continue
  // ------------------------------------------------------------
  logic stop_q;
  logic cont_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (power_up_pulse) begin
      stop_q <= 1'b0;
      cont_q <= 1'b0;
    end else if (run_enable) begin
      stop_q <= !stop_key_n;
      cont_q <= !cont_key_n;
    end else begin
      stop_q <= 1'b0;
      cont_q <= 1'b0;
    end
  end
  assign stop_out = stop_q;
  assign cont_out = cont_q;

  // ------------------------------------------------------------
  // Lamps, levers and pass-through
  // ------------------------------------------------------------
  kse_pkg::kse_lamps_t lamps_q;
  kse_pkg::kse_levers_t levers_q;
  logic [15:0] sw_q;
  logic [6:0] bs_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamps_q <= '0;
      levers_q <= '1;
      sw_q <= '0;
      bs_q <= '1;
    end else begin
      lamps_q.ready_lamp <= !ready_in_n | stop_q;
      lamps_q.busy_lamp <= ready_in_n;
      lamps_q.query_lamp <= !query_level_in;
      lamps_q.bs_lamps <= ~block_size_selects;
      bs_q <= block_size_selects;
      levers_q.step_n <= !step_lever;
      levers_q.repeat_n <= !repeat_lever;
      sw_q <= switch_in;
    end
  end
  assign lamps = lamps_q;
  assign levers = levers_q;
  assign block_size_to_adc = bs_q;
  // Restart is not passed through the switch path
  assign switch_out = sw_q;

  // Read mux
  always_comb begin
    rdata_d = '0;
    if (take && addr_ok && !hwrite) begin
      unique case (haddr[kse_pkg::REG_ADDR_W-1:0])
        kse_pkg::CTRL_OFFSET: rdata_d = {30'h0, ctrl_q};
        kse_pkg::STATUS_OFFSET:
          rdata_d = {20'h0, stop_q, cont_q, bits_q, 2'(state_q),
                     busy, out_q, restart_in};
        kse_pkg::LAMP_OFFSET: rdata_d = {22'h0, lamps_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule
